/* logic/e1_sa_datalink_ctrl.sv */
// Transmit Sa bit data link control with APB registers
`timescale 1ns/100ps

// Function
// - Register bit 7 lets Sa8 (timeslot 0 bit 7) carry data link
// - Register bit 6 lets Sa7 (timeslot 0 bit 6) carry data link
// - Register bit 5 lets Sa6 (timeslot 0 bit 5) carry data link
// - Register bit 4 lets Sa5 (timeslot 0 bit 4) carry data link
// - Register bit 3 lets Sa4 (timeslot 0 bit 3) carry data link
// - All five enables are read/write and reset to zero
// - Disabled Sa bit from serial input is sent as one
// - Enabled Sa bit in every non-FAS frame is open to data link
// - Data link only when source is HDLC and bit select is serial
// - Each Sa bit comes from serial input or register per select bit
module e1_sa_datalink_ctrl
    import e1_sa_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [15:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  in_word_s         in_data,
    input  wire logic        in_valid,
    output logic             in_ready,
    output out_word_s        out_data,
    output logic             out_valid,
    input  wire logic        out_ready
);
    typedef struct packed {
        chan_regs_s [NUM_CH-1:0] regs;
        logic [31:0]             rdata;
        logic                    ready;
        logic                    err;
    } top_s;

    top_s               st;
    top_s               next_st;
    logic [7:0]         octet_ch [NUM_CH];
    out_word_s          ins_word;
    logic [13:0]        idx;
    logic [CH_W-1:0]    acc_ch;
    logic [7:0]         acc_off;
    logic               acc_hit;
    logic [7:0]         rd_byte;

    // Index decode: channel in the upper part, register in the low byte
    assign idx     = paddr[15:2];
    assign acc_ch  = idx[8 +: CH_W];
    assign acc_off = idx[7:0];

    // Register address valid check
    function automatic logic reg_known(input logic [7:0] off);
        reg_known = (off == IDX_DL_SRC) || (off == IDX_TSDL) ||
                    (off == IDX_SASEL) || (off == IDX_SAVAL) ||
                    (off == IDX_STATUS);
    endfunction

    assign acc_hit = (paddr[1:0] == 2'h0) &&
                     (idx[13:8] < 6'(NUM_CH)) && reg_known(acc_off);

    // One insertion stage per channel, each seeing only its own registers
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        sa_bit_insert u_ins (
            .regs  (st.regs[c]),
            .word  (in_data),
            .octet (octet_ch[c])
        );
    end

    // Pick the insertion result of the word's own channel
    always_comb begin
        ins_word.ch    = in_data.ch;
        ins_word.octet = octet_ch[in_data.ch];
    end

    // Stall-safe path toward the line
    word_pair_buffer u_buf (
        .pclk      (pclk),
        .presetn   (presetn),
        .in_data   (ins_word),
        .in_valid  (in_valid),
        .in_ready  (in_ready),
        .out_data  (out_data),
        .out_valid (out_valid),
        .out_ready (out_ready)
    );

    // Read data selection for the addressed channel
    always_comb begin
        chan_regs_s r;
        r       = st.regs[acc_ch];
        rd_byte = 8'h00;
        case (acc_off)
            IDX_TSDL:   rd_byte = r.tx_signaling_datalink_select;
            IDX_DL_SRC: rd_byte = {6'h00, r.datalink_source_field};
            IDX_SASEL:  rd_byte = {r.spare_source_select, 3'h0};
            IDX_SAVAL:  rd_byte = {r.spare_insert_value, 3'h0};
            IDX_STATUS: rd_byte = {dl_active(r), 3'h0};
            default:    rd_byte = 8'h00;
        endcase
    end

    // APB slave: answer one cycle after setup, write at the access edge
    always_comb begin
        next_st       = st;
        next_st.ready = 1'b0;
        if (psel && !penable && !st.ready) begin
            next_st.ready = 1'b1;
            next_st.err   = ~acc_hit;
            next_st.rdata = acc_hit ? {24'h0, rd_byte} : 32'h0;
        end
        if (psel && penable && st.ready) begin
            next_st.err = 1'b0;
            if (pwrite && acc_hit) begin
                case (acc_off)
                    IDX_TSDL: begin
                        // Bits 7..3 enable Sa8..Sa4 for data link
                        next_st.regs[acc_ch].tx_signaling_datalink_select =
                            pwdata[7:0];
                    end
                    IDX_DL_SRC: begin
                        next_st.regs[acc_ch].datalink_source_field =
                            pwdata[1:0];
                    end
                    IDX_SASEL: begin
                        next_st.regs[acc_ch].spare_source_select =
                            pwdata[7:3];
                    end
                    IDX_SAVAL: begin
                        next_st.regs[acc_ch].spare_insert_value =
                            pwdata[7:3];
                    end
                    default: begin
                        next_st.err = 1'b0;
                    end
                endcase
            end
        end
    end

    assign prdata  = st.rdata;
    assign pready  = st.ready;
    assign pslverr = st.err;

    // State register; enables come out of reset cleared
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int c = 0; c < NUM_CH; c++) begin
                st.regs[c].tx_signaling_datalink_select <= TSDL_RST;
                st.regs[c].datalink_source_field        <= DL_SRC_RST;
                st.regs[c].spare_source_select          <= SASEL_RST;
                st.regs[c].spare_insert_value           <= SAVAL_RST;
            end
            st.rdata <= 32'h0;
            st.ready <= 1'b0;
            st.err   <= 1'b0;
        end else begin
            st <= next_st;
        end
    end
endmodule

/* logic/e1_sa_pkg.sv */
// Constants, register layout and carriers for the Sa bit data link control
package e1_sa_pkg;
    // Channel count and width of the channel field
    localparam int NUM_CH = 2;
    localparam int CH_W   = 1;

    // Register indices; byte address is four times the index
    localparam logic [13:0] CH_STRIDE   = 14'h0100;
    localparam logic [7:0]  IDX_DL_SRC  = 8'h09;
    localparam logic [7:0]  IDX_TSDL    = 8'h0a;
    localparam logic [7:0]  IDX_SASEL   = 8'h30;
    localparam logic [7:0]  IDX_SAVAL   = 8'h31;
    localparam logic [7:0]  IDX_STATUS  = 8'h32;

    // Field positions and values
    localparam int          SPARE_LSB   = 3;
    localparam int          SPARE_N     = 5;
    localparam logic [1:0]  DL_SRC_HDLC = 2'h1;

    // Values after reset
    localparam logic [7:0]  TSDL_RST    = 8'h00;
    localparam logic [1:0]  DL_SRC_RST  = 2'h0;
    localparam logic [4:0]  SASEL_RST   = 5'h00;
    localparam logic [4:0]  SAVAL_RST   = 5'h1f;

    // Per channel register contents
    typedef struct packed {
        logic [7:0] tx_signaling_datalink_select;
        logic [1:0] datalink_source_field;
        logic [4:0] spare_source_select;
        logic [4:0] spare_insert_value;
    } chan_regs_s;

    // Octet entering the insertion stage
    typedef struct packed {
        logic [CH_W-1:0] ch;
        logic            ts0_nonfas;
        logic [4:0]      dl_bits;
        logic [7:0]      octet;
    } in_word_s;

    // Octet leaving toward the line
    typedef struct packed {
        logic [CH_W-1:0] ch;
        logic [7:0]      octet;
    } out_word_s;

    // Spare positions that really carry data link bits
    function automatic logic [4:0] dl_active(input chan_regs_s r);
        logic [4:0] en;
        en = r.tx_signaling_datalink_select[SPARE_LSB +: SPARE_N];
        if (r.datalink_source_field == DL_SRC_HDLC) begin
            dl_active = en & ~r.spare_source_select;
        end else begin
            dl_active = 5'h00;
        end
    endfunction
endpackage

/* logic/sa_bit_insert.sv */
// Spare bit insertion for one channel's timeslot 0 octet
`timescale 1ns/100ps
module sa_bit_insert
    import e1_sa_pkg::*;
(
    input  chan_regs_s regs,
    input  in_word_s   word,
    output logic [7:0] octet
);
    logic [4:0] en;
    logic [4:0] act;

    assign en  = regs.tx_signaling_datalink_select[SPARE_LSB +: SPARE_N];
    assign act = dl_active(regs);

    // Choose each spare bit source, non-FAS timeslot 0 only
    always_comb begin
        octet = word.octet;
        if (word.ts0_nonfas) begin
            for (int k = 0; k < SPARE_N; k++) begin
                if (regs.spare_source_select[k]) begin
                    octet[SPARE_LSB+k] = regs.spare_insert_value[k];
                end else if (act[k]) begin
                    octet[SPARE_LSB+k] = word.dl_bits[k];
                end else if (!en[k]) begin
                    octet[SPARE_LSB+k] = 1'b1;
                end
            end
        end
    end
endmodule

/* logic/word_pair_buffer.sv */
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/100ps
module word_pair_buffer
    import e1_sa_pkg::*;
(
    input  wire logic      pclk,
    input  wire logic      presetn,
    input  out_word_s      in_data,
    input  wire logic      in_valid,
    output logic           in_ready,
    output out_word_s      out_data,
    output logic           out_valid,
    input  wire logic      out_ready
);
    typedef struct packed {
        out_word_s head;
        out_word_s tail;
        logic      head_v;
        logic      tail_v;
        logic      ready;
    } buf_s;

    buf_s st;
    buf_s next_st;
    logic push;
    logic pop;

    assign push      = in_valid & st.ready;
    assign pop       = out_ready & st.head_v;
    assign in_ready  = st.ready;
    assign out_data  = st.head;
    assign out_valid = st.head_v;

    // Head always holds the oldest word
    always_comb begin
        next_st = st;
        if (pop) begin
            next_st.head   = st.tail;
            next_st.head_v = st.tail_v;
            next_st.tail_v = 1'b0;
            if (push && st.tail_v) begin
                next_st.tail   = in_data;
                next_st.tail_v = 1'b1;
            end else if (push) begin
                next_st.head   = in_data;
                next_st.head_v = 1'b1;
            end
        end else if (push) begin
            if (st.head_v) begin
                next_st.tail   = in_data;
                next_st.tail_v = 1'b1;
            end else begin
                next_st.head   = in_data;
                next_st.head_v = 1'b1;
            end
        end
        next_st.ready = ~next_st.tail_v;
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '{head: '0, tail: '0, head_v: 1'b0, tail_v: 1'b0,
                    ready: 1'b1};
        end else begin
            st <= next_st;
        end
    end
endmodule

/* verification/e1_sa_checker_assertions.sv */
// Port checks for the Sa data link control block
`timescale 1ns/100ps
module e1_sa_checker
    import e1_sa_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [15:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        in_valid,
    input wire logic        in_ready,
    input out_word_s        out_data,
    input wire logic        out_valid,
    input wire logic        out_ready
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Setup phase and its single-cycle answer
    sequence s_setup;
        psel && !penable && !pready;
    endsequence
    sequence s_answer;
        pready ##1 !pready;
    endsequence
    a_setup_answer: assert property (s_setup |=> s_answer)
        else $error("setup not answered in one cycle");
    a_idle_quiet: assert property (!psel |=> !pready)
        else $error("answer without a request");
    a_misalign_err: assert property (s_setup and paddr[1:0] != 2'h0
        |=> pslverr && prdata == 32'h0) else $error("misaligned accepted");
    a_chan_range: assert property (s_setup and paddr[15:11] != 5'h00
        |=> pslverr) else $error("channel out of range accepted");
    a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    a_out_hold: assert property (out_valid && !out_ready
        |=> out_valid && $stable(out_data)) else $error("word dropped");
    a_first_out: assert property (in_valid && in_ready && !out_valid
        |=> out_valid) else $error("taken word not offered");
    a_full_refuse: assert property (!in_ready |-> out_valid)
        else $error("refusal while empty");
endmodule

bind e1_sa_datalink_ctrl e1_sa_checker chk_u(.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .in_valid(in_valid),
    .in_ready(in_ready), .out_data(out_data), .out_valid(out_valid),
    .out_ready(out_ready));

/* verification/line_sink.sv */
// Outbound line side: takes octets, stalls at random or on command
`timescale 1ns/100ps
module line_sink (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic stall,
    output logic      out_ready
);
    int seed = 32'h5a9b;
    // Ready drawn afresh each cycle, held low while stalled
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            out_ready <= 1'b0;
        else
            out_ready <= !stall && ($random(seed) % 3 != 0);
    end
endmodule

/* verification/test_e1_sa_datalink_ctrl.sv */
// Self-checking bench for the Sa data link control block
`timescale 1ns/100ps
module test_e1_sa_datalink_ctrl
    import e1_sa_pkg::*;
();
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        in_valid, in_ready, out_valid, out_ready, stall, cc;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata;
    in_word_s    in_data;
    out_word_s   out_data;
    int          mismatches, samples_checked, seed;
    logic [32:0] rq[$];
    logic [8:0]  oq[$];
    logic [7:0]  tsdl[2], sel[2], val[2];
    logic [1:0]  src[2];

    e1_sa_datalink_ctrl dut_u(.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .in_data(in_data), .in_valid(in_valid), .in_ready(in_ready),
        .out_data(out_data), .out_valid(out_valid), .out_ready(out_ready));
    line_sink sink_u(.pclk(pclk), .presetn(presetn), .stall(stall),
        .out_ready(out_ready));

    task chk(input logic [32:0] seen, input logic [32:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task print_verdict();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    function logic [15:0] ad(input logic c, input logic [7:0] i);
        return {5'h00, c, i, 2'h0};
    endfunction

    // Positions that really carry data link bits
    function logic [7:0] st(input logic c);
        return (src[c] == 2'h1) ? (tsdl[c] & ~sel[c] & 8'hf8) : 8'h00;
    endfunction

    // Outbound octet worked out from the channel's register images
    function logic [7:0] exp_oct(input in_word_s x);
        exp_oct = x.octet;
        if (x.ts0_nonfas)
            for (int k = 3; k < 8; k++)
                if (sel[x.ch][k]) exp_oct[k] = val[x.ch][k];
                else if (tsdl[x.ch][k] && src[x.ch] == DL_SRC_HDLC)
                    exp_oct[k] = x.dl_bits[k-3];
                else if (!tsdl[x.ch][k]) exp_oct[k] = 1'b1;
    endfunction

    task apb(input logic wr, input logic [15:0] a, input logic [7:0] v,
             input logic [32:0] exp);
        rq.push_back(exp);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'($random(seed)), v};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle edge so the next setup never reassigns psel in this step
        @(posedge pclk);
    endtask

    task send(input in_word_s x);
        in_data <= x;
        in_valid <= 1'b1;
        do @(posedge pclk); while (in_ready !== 1'b1);
        oq.push_back({x.ch, exp_oct(x)});
    endtask

    // Scoreboard for register answers and outbound octets
    always @(posedge pclk) begin
        if (psel && penable && pready)
            chk({pslverr, pwrite ? 32'h0 : prdata}, rq.pop_front());
        if (out_valid && out_ready)
            chk({24'h0, out_data}, {24'h0, oq.pop_front()});
    end

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    initial begin
        #2000000;
        mismatches++;
        print_verdict();
    end

    initial begin
        {psel, penable, pwrite, paddr, pwdata, in_valid, stall} = '0;
        in_data = '0;
        presetn = 1'b0;
        seed = 32'h5a9b;
        mismatches = 0;
        samples_checked = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // Values after reset, then refused places
        for (int i = 0; i < 2; i++) begin
            cc = 1'(i);
            {tsdl[cc], sel[cc], val[cc], src[cc]} = {16'h0, 8'hf8, 2'h0};
            apb(1'b0, ad(cc, IDX_TSDL), 8'h00, 33'h0);
            apb(1'b0, ad(cc, IDX_SAVAL), 8'h00, 33'hf8);
            apb(1'b0, ad(cc, IDX_STATUS), 8'h00, 33'h0);
        end
        apb(1'b0, ad(1'b0, 8'h00), 8'h00, {1'b1, 32'h0});
        apb(1'b1, ad(1'b0, IDX_TSDL) | 16'h1, 8'hff, {1'b1, 32'h0});
        apb(1'b0, ad(1'b0, IDX_TSDL) | 16'h800, 8'h00, {1'b1, 32'h0});
        apb(1'b0, ad(1'b0, IDX_TSDL), 8'h00, 33'h0);
        // Random settings per channel, each followed by a burst of octets
        repeat (40) begin
            cc = 1'($random(seed));
            tsdl[cc] = 8'($random(seed));
            src[cc] = ($random(seed) & 1) ? DL_SRC_HDLC : 2'($random(seed));
            sel[cc] = 8'($random(seed)) & 8'hf8;
            val[cc] = 8'($random(seed)) & 8'hf8;
            apb(1'b1, ad(cc, IDX_TSDL), tsdl[cc], 33'h0);
            apb(1'b1, ad(cc, IDX_DL_SRC), {6'h0, src[cc]}, 33'h0);
            apb(1'b1, ad(cc, IDX_SASEL), sel[cc], 33'h0);
            apb(1'b1, ad(cc, IDX_SAVAL), val[cc], 33'h0);
            apb(1'b0, ad(cc, IDX_TSDL), 8'h00, {25'h0, tsdl[cc]});
            apb(1'b0, ad(cc, IDX_STATUS), 8'h00, {25'h0, st(cc)});
            repeat (6) send(in_word_s'(15'($random(seed))));
            in_valid <= 1'b0;
        end
        // Stalled sink: fill both entries, expect refusal, then drain
        while (oq.size() != 0) @(posedge pclk);
        stall <= 1'b1;
        repeat (2) @(posedge pclk);
        send(in_word_s'(15'($random(seed))));
        send(in_word_s'(15'($random(seed))));
        in_valid <= 1'b0;
        @(posedge pclk);
        chk({31'h0, in_ready, out_valid}, 33'h1);
        stall <= 1'b0;
        while (oq.size() != 0) @(posedge pclk);
        repeat (3) @(posedge pclk);
        // Mid-run reset clears the enables set by the random phase
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, ad(1'b0, IDX_TSDL), 8'h00, 33'h0);
        apb(1'b0, ad(1'b1, IDX_TSDL), 8'h00, 33'h0);
        print_verdict();
    end
endmodule
